//--- logic/tra_regs.svh
`ifndef TRA_REGS_SVH
`define TRA_REGS_SVH
// ----------------------------------------
// queue depths and per-requestor limits
// ----------------------------------------
`define TRA_URG_LAST 4'h5
`define TRA_HIGH_LAST 4'hC
`define TRA_LOW_LAST 4'hA
`define TRA_URG_DEPTH 5'h06
`define TRA_HIGH_DEPTH 5'h0D
`define TRA_LOW_DEPTH 5'h0B
`define TRA_LIM_CACHE_URG 4'h6
`define TRA_LIM_QUICK_HIGH 4'h3
`define TRA_LIM_QUICK_LOW 4'h3
`define TRA_LIM_CHAN_HIGH 4'h8
`define TRA_LIM_CHAN_LOW 4'h8
`define TRA_LIM_HOST_HIGH 4'h2
// ----------------------------------------
// port command buffers and timing
// ----------------------------------------
`define TRA_L2_RD_BUFS 4'h8
`define TRA_L2_RD_WORDS 8'h02
`define TRA_EXT_WR_BUFS 2'h2
`define TRA_EXT_WR_WORDS 8'h10
`define TRA_SUB_DELAY 2'h2
`define TRA_LVL_URG 2'h0
`define TRA_LVL_HIGH 2'h1
`endif

//--- logic/tra_pkg.sv
package tra_pkg;
  typedef enum logic [1:0] {TRA_SUB_IDLE = 2'b01, TRA_SUB_WAIT = 2'b10} tra_sub_st_t;
  typedef struct packed {logic [1:0] lvl; logic [7:0] words;} tra_xfer_req_packet_t;
  typedef struct packed {logic [1:0] node; logic [7:0] words;} tra_qent_t;
  typedef struct packed {logic vld; logic [1:0] node; logic [7:0] rd_left; logic [7:0] acc;} tra_act_t;
  typedef struct packed {logic vld; logic [1:0] lvl;} tra_rcmd_t;
  typedef struct packed {logic vld; logic [1:0] lvl; logic [4:0] words;} tra_wcmd_t;
  typedef struct packed {
    tra_sub_st_t sub;
    logic [1:0] sub_cnt;
    logic [1:0] sub_lvl;
    tra_qent_t sub_ent;
    logic [1:0] rr;
    logic [3:0][3:0] age;
    logic [3:0] ack;
    logic [3:0] stall;
    logic [3:0][2:0][3:0] outst;
    logic [3:0] evt_pend;
    tra_qent_t [2:0][15:0] q;
    logic [2:0][3:0] qwp;
    logic [2:0][3:0] qrp;
    logic [2:0][4:0] qcnt;
    tra_act_t [2:0] act;
    logic [7:0][1:0] rq;
    logic [2:0] rwp;
    logic [2:0] rrp;
    logic [3:0] rcnt;
    logic [1:0][6:0] wq;
    logic wwp;
    logic wrp;
    logic [1:0] wcnt;
    tra_rcmd_t l2_out;
    tra_wcmd_t ext_out;
    logic [2:0] busy;
  } tra_state_t;
endpackage

//--- logic/tra_arbiter.sv
`timescale 1ns/1ns
// Functional notes
// [RULE1] stalled requestor forwards nothing until cleared
// [RULE2] unstalled requests forwarded in arrival order
// [RULE3] simultaneous arrivals round-robin, two cycles each
// [RULE4] each priority queue is strict fifo
// [RULE5] free active set takes its queue head
// [RULE6] up to three transfers active at once
// [RULE7] shared port goes to higher priority transfer
// [RULE8] urgent beats high beats low
// [RULE9] port busy only while moving data
// [RULE10] keep issuing while command buffers have room
// [RULE11] second-level port: eight two-word read buffers
// [RULE12] external port: two sixteen-word write buffers
// [RULE13] external write starts once one buffer full
// [RULE14] new higher transfer wins from first cycle
// [RULE15] ports run buffered commands in arrival order
// [RULE16] second-level port may switch, external keeps draining
// [RULE17] queue depths six, thirteen, eleven; per-requestor limits
// [RULE18] over-limit requestor stalls until one activates
// [RULE19] channel events latched during stall, repeats merge
// [RULE20] round-robin pointer moves past granted node
`include "tra_regs.svh"
module tra_arbiter import tra_pkg::*; (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cache_req_vld,
  input wire tra_xfer_req_packet_t cache_req,
  input wire logic quick_req_vld,
  input wire tra_xfer_req_packet_t quick_req,
  input wire logic host_req_vld,
  input wire tra_xfer_req_packet_t host_req,
  input wire logic [3:0] chan_evt,
  input wire logic [7:0] chan_evt_lvl,
  input wire logic [7:0] chan_words,
  output logic [3:0] req_ack,
  output logic [3:0] req_stall,
  output tra_rcmd_t l2_cmd,
  input wire logic l2_cmd_done,
  output tra_wcmd_t ext_cmd,
  input wire logic ext_cmd_ready,
  output logic [2:0] xfer_active
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic [3:0] lim(input logic [1:0] n, input logic [1:0] l);
    case ({n, l})
      4'h0: lim = `TRA_LIM_CACHE_URG;
      4'h5: lim = `TRA_LIM_QUICK_HIGH;
      4'h6: lim = `TRA_LIM_QUICK_LOW;
      4'h9: lim = `TRA_LIM_CHAN_HIGH;
      4'hA: lim = `TRA_LIM_CHAN_LOW;
      4'hD: lim = `TRA_LIM_HOST_HIGH;
      default: lim = 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] nxt(input logic [3:0] p, input logic [1:0] l);
    logic [3:0] last;
    last = (l == 2'h0) ? `TRA_URG_LAST : (l == 2'h1) ? `TRA_HIGH_LAST : `TRA_LOW_LAST;
    nxt = (p == last) ? 4'h0 : p + 4'h1; // [RULE17]
  endfunction

  tra_state_t s_q;
  tra_state_t d;
  tra_qent_t e;
  logic [3:0] v;
  logic [3:0] elig;
  logic [3:0] stall_n;
  logic [3:0][1:0] lvln;
  logic [3:0] evt_clr;
  logic [1:0] cidx;
  logic [1:0] pick;
  logic [1:0] n;
  logic found;
  logic done_r;
  logic done_w;
  logic [7:0] wn;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = s_q;
    d.ack = 4'h0;
    e = '0;
    evt_clr = 4'h0;
    done_r = 1'b0;
    done_w = 1'b0;
    wn = 8'h00;
    found = 1'b0;
    pick = 2'h0;
    n = 2'h0;
    // port drains; the port decides when it is actually moving data
    if (l2_cmd_done && s_q.rcnt != 4'h0) begin // [RULE9]
      d.rrp = s_q.rrp + 3'h1; // [RULE15]
      d.rcnt = d.rcnt - 4'h1;
    end
    if (s_q.ext_out.vld && ext_cmd_ready) begin // [RULE15]
      d.wrp = ~s_q.wrp;
      d.wcnt = d.wcnt - 2'h1;
    end
    // active sets retire, or load their queue head
    for (int l = 0; l < 3; l++) begin // [RULE6]
      if (s_q.act[l].vld && s_q.act[l].rd_left == 8'h00 && s_q.act[l].acc == 8'h00) begin
        d.act[l].vld = 1'b0;
      end else if (!s_q.act[l].vld && s_q.qcnt[l] != 5'h00) begin // [RULE5]
        e = s_q.q[l][s_q.qrp[l]];
        d.act[l] = '{vld: 1'b1, node: e.node, rd_left: e.words, acc: 8'h00};
        d.qrp[l] = nxt(s_q.qrp[l], 2'(l)); // [RULE4]
        d.qcnt[l] = d.qcnt[l] - 5'h01;
        d.outst[e.node][l] = d.outst[e.node][l] - 4'h1; // [RULE18]
      end
    end
    // read commands: lowest level number wins the second-level port
    for (int l = 0; l < 3; l++) begin // [RULE7] [RULE8] [RULE14]
      if (!done_r && s_q.act[l].vld && s_q.act[l].rd_left != 8'h00 && s_q.rcnt < `TRA_L2_RD_BUFS) begin // [RULE10]
        done_r = 1'b1;
        wn = (s_q.act[l].rd_left < `TRA_L2_RD_WORDS) ? s_q.act[l].rd_left : `TRA_L2_RD_WORDS; // [RULE11]
        d.act[l].rd_left = s_q.act[l].rd_left - wn; // [RULE16]
        d.act[l].acc = s_q.act[l].acc + wn;
        d.rq[s_q.rwp] = 2'(l);
        d.rwp = s_q.rwp + 3'h1;
        d.rcnt = d.rcnt + 4'h1;
      end
    end
    // write commands: a full sixteen-word buffer goes out, tail when reads are done
    for (int l = 0; l < 3; l++) begin // [RULE7] [RULE8]
      if (!done_w && s_q.act[l].vld && s_q.wcnt < `TRA_EXT_WR_BUFS &&
          (s_q.act[l].acc >= `TRA_EXT_WR_WORDS ||
           (s_q.act[l].rd_left == 8'h00 && s_q.act[l].acc != 8'h00))) begin // [RULE13]
        done_w = 1'b1;
        wn = (s_q.act[l].acc < `TRA_EXT_WR_WORDS) ? s_q.act[l].acc : `TRA_EXT_WR_WORDS; // [RULE12]
        d.act[l].acc = d.act[l].acc - wn;
        d.wq[s_q.wwp] = {2'(l), wn[4:0]};
        d.wwp = ~s_q.wwp;
        d.wcnt = d.wcnt + 2'h1;
      end
    end
    // requestor nodes: cache, quick, channel, host
    cidx = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (s_q.evt_pend[i]) begin
        cidx = 2'(i);
      end
    end
    v = {host_req_vld, s_q.evt_pend != 4'h0, quick_req_vld, cache_req_vld};
    lvln[0] = `TRA_LVL_URG;
    lvln[1] = quick_req.lvl;
    lvln[2] = chan_evt_lvl[{cidx, 1'b0} +: 2];
    lvln[3] = `TRA_LVL_HIGH;
    for (int i = 0; i < 4; i++) begin
      stall_n[i] = v[i] && (lvln[i] > 2'h2 || s_q.outst[i][lvln[i]] >= lim(2'(i), lvln[i])); // [RULE18]
      elig[i] = v[i] && !stall_n[i] && !s_q.ack[i]; // [RULE1]
    end
    d.stall = stall_n;
    // oldest waiting node first, ties broken from the round-robin pointer
    for (int k = 0; k < 4; k++) begin // [RULE2] [RULE3]
      n = s_q.rr + 2'(k);
      if (elig[n] && (!found || s_q.age[n] > s_q.age[pick])) begin
        found = 1'b1;
        pick = n;
      end
    end
    unique case (s_q.sub)
      TRA_SUB_IDLE: begin
        if (found) begin
          d.sub = TRA_SUB_WAIT;
          d.sub_cnt = `TRA_SUB_DELAY - 2'h1; // [RULE3]
          d.sub_lvl = lvln[pick];
          d.sub_ent.node = pick;
          d.sub_ent.words = (pick == 2'h0) ? cache_req.words : (pick == 2'h1) ? quick_req.words :
                            (pick == 2'h2) ? chan_words : host_req.words;
          d.ack[pick] = 1'b1;
          d.rr = pick + 2'h1; // [RULE20]
          d.outst[pick][lvln[pick]] = d.outst[pick][lvln[pick]] + 4'h1;
          if (pick == 2'h2) begin
            evt_clr[cidx] = 1'b1;
          end
        end
      end
      TRA_SUB_WAIT: begin
        if (s_q.sub_cnt == 2'h1) begin
          d.q[s_q.sub_lvl][s_q.qwp[s_q.sub_lvl]] = s_q.sub_ent; // [RULE4]
          d.qwp[s_q.sub_lvl] = nxt(s_q.qwp[s_q.sub_lvl], s_q.sub_lvl);
          d.qcnt[s_q.sub_lvl] = d.qcnt[s_q.sub_lvl] + 5'h01;
          d.sub = TRA_SUB_IDLE;
        end else begin
          d.sub_cnt = s_q.sub_cnt - 2'h1;
        end
      end
    endcase
    for (int i = 0; i < 4; i++) begin
      if (!v[i] || d.ack[i]) begin
        d.age[i] = 4'h0;
      end else if (s_q.age[i] != 4'hF) begin
        d.age[i] = s_q.age[i] + 4'h1;
      end
    end
    // a repeat of a pending event merges; a new event beats its own clear
    d.evt_pend = (s_q.evt_pend & ~evt_clr) | chan_evt; // [RULE19]
    d.l2_out = '{vld: d.rcnt != 4'h0, lvl: d.rq[d.rrp]};
    d.ext_out = {d.wcnt != 2'h0, d.wq[d.wrp]};
    d.busy = {d.act[2].vld, d.act[1].vld, d.act[0].vld};
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.sub <= TRA_SUB_IDLE;
    end else begin
      s_q <= d;
    end
  end

  assign req_ack = s_q.ack;
  assign req_stall = s_q.stall;
  assign l2_cmd = s_q.l2_out;
  assign ext_cmd = s_q.ext_out;
  assign xfer_active = s_q.busy;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_stall_no_ack: assert property ((s_q.stall & s_q.ack) == 4'h0) // [RULE1]
    else $error("stalled requestor was granted");
  a_sub_two_cycles: assert property ((|s_q.ack) |-> s_q.sub == TRA_SUB_WAIT ##1 s_q.sub == TRA_SUB_IDLE) // [RULE3]
    else $error("submission delay wrong");
  a_rr_pointer: assert property ((|s_q.ack) |-> $onehot(s_q.ack) && s_q.ack[2'(s_q.rr - 2'h1)]) // [RULE20]
    else $error("round-robin pointer not past grant");
  a_queue_depth: assert property (s_q.qcnt[0] <= `TRA_URG_DEPTH && s_q.qcnt[1] <= `TRA_HIGH_DEPTH &&
                                  s_q.qcnt[2] <= `TRA_LOW_DEPTH) // [RULE17]
    else $error("priority queue overflow");
  a_act_load: assert property ((!s_q.act[1].vld && s_q.qcnt[1] != 5'h00) |=> s_q.act[1].vld) // [RULE5]
    else $error("free active set did not load");
  a_urgent_read: assert property ((s_q.act[0].vld && s_q.act[0].rd_left != 8'h00 && s_q.rcnt < `TRA_L2_RD_BUFS)
                                  |=> s_q.rq[$past(s_q.rwp)] == 2'h0) // [RULE8]
    else $error("urgent transfer lost port arbitration");
  a_l2_bufs: assert property ((s_q.rcnt == `TRA_L2_RD_BUFS && !l2_cmd_done) |=> $stable(s_q.rwp)) // [RULE10]
    else $error("read issued into full buffers");
  a_ext_bufs: assert property (s_q.wcnt <= `TRA_EXT_WR_BUFS && (!s_q.ext_out.vld || s_q.ext_out.words <= 5'h10)) // [RULE12]
    else $error("external write buffer misuse");
  a_evt_kept: assert property ((chan_evt != 4'h0) |=> (s_q.evt_pend & $past(chan_evt)) == $past(chan_evt)) // [RULE19]
    else $error("channel event lost");
endmodule

//--- tb/tra_port_model.sv
`timescale 1ns/1ns
module tra_port_model import tra_pkg::*; (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hold,
  input wire tra_rcmd_t l2_cmd,
  input wire tra_wcmd_t ext_cmd,
  output logic l2_cmd_done,
  output logic ext_cmd_ready
);
  // ----------------------------------------
  // far-side ports, can stall on hold
  // ----------------------------------------
  // done only every other cycle: a slow port exposes the busy gaps
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      l2_cmd_done <= 1'b0;
    end else begin
      l2_cmd_done <= l2_cmd.vld && !hold && !l2_cmd_done;
    end
  end
  assign ext_cmd_ready = !hold;
endmodule

//--- tb/tra_arbiter_bench.sv
`timescale 1ns/1ns
module tra_arbiter_bench import tra_pkg::*;;
  logic mclk, rst_b, hold, cache_req_vld, quick_req_vld, host_req_vld, l2_cmd_done, ext_cmd_ready;
  tra_xfer_req_packet_t cache_req, quick_req, host_req;
  logic [3:0] chan_evt, req_ack, req_stall;
  logic [7:0] chan_evt_lvl, chan_words;
  tra_rcmd_t l2_cmd;
  tra_wcmd_t ext_cmd;
  logic [2:0] xfer_active;
  logic [1:0] seq[$];
  logic [4:0] ewq[$];
  int mismatches, check_count;
  tra_arbiter u_dut (.mclk(mclk), .rst_b(rst_b), .cache_req_vld(cache_req_vld), .cache_req(cache_req),
    .quick_req_vld(quick_req_vld), .quick_req(quick_req), .host_req_vld(host_req_vld), .host_req(host_req),
    .chan_evt(chan_evt), .chan_evt_lvl(chan_evt_lvl), .chan_words(chan_words), .req_ack(req_ack),
    .req_stall(req_stall), .l2_cmd(l2_cmd), .l2_cmd_done(l2_cmd_done), .ext_cmd(ext_cmd),
    .ext_cmd_ready(ext_cmd_ready), .xfer_active(xfer_active));
  tra_port_model u_port (.mclk(mclk), .rst_b(rst_b), .hold(hold), .l2_cmd(l2_cmd), .ext_cmd(ext_cmd),
    .l2_cmd_done(l2_cmd_done), .ext_cmd_ready(ext_cmd_ready));
  // ----------------------------------------
  // clock, monitors, helpers
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (l2_cmd_done && l2_cmd.vld) seq.push_back(l2_cmd.lvl);
    if (ext_cmd.vld && ext_cmd_ready) ewq.push_back(ext_cmd.words);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic drive(input int n, input logic v, input tra_xfer_req_packet_t p);
    case (n)
      0: begin cache_req_vld <= v; cache_req <= p; end
      1: begin quick_req_vld <= v; quick_req <= p; end
      default: begin host_req_vld <= v; host_req <= p; end
    endcase
  endtask
  // cyc counts edges from raising valid to seeing the ack
  task automatic submit(input int n, input logic [1:0] lvl, input logic [7:0] w, input int lim, output int cyc);
    tra_xfer_req_packet_t p;
    p.lvl = lvl;
    p.words = w;
    cyc = 0;
    @(posedge mclk) drive(n, 1'b1, p);
    do begin @(posedge mclk); #1; cyc++; end while (req_ack[n] !== 1'b1 && cyc < lim);
    @(posedge mclk) drive(n, 1'b0, p);
  endtask
  task automatic drain();
    int k;
    k = 0;
    repeat (6) @(posedge mclk);
    while (k < 2000 && (xfer_active !== 3'h0 || l2_cmd.vld !== 1'b0 || ext_cmd.vld !== 1'b0)) begin
      @(posedge mclk); k++;
    end
    #1 check(xfer_active, 3'h0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_single();
    int c;
    seq.delete(); ewq.delete();
    submit(0, 2'h0, 8'h10, 8, c);
    check(c >= 1 && c <= 4, 1);
    drain();
    check(seq.size(), 8);
    check(ewq.size() > 0 ? ewq[0] : 5'h00, 5'h10);
  endtask
  task automatic t_pair();
    int a1, a3, n1, n3;
    tra_xfer_req_packet_t p;
    p.lvl = 2'h1; p.words = 8'h02;
    a1 = -9; a3 = -9; n1 = 0; n3 = 0; seq.delete();
    @(posedge mclk) begin drive(1, 1'b1, p); drive(3, 1'b1, p); end
    for (int i = 1; i < 30; i++) begin
      @(posedge mclk);
      if (a1 == i - 1) drive(1, 1'b0, p);
      if (a3 == i - 1) drive(3, 1'b0, p);
      #1;
      if (req_ack[1] === 1'b1) begin a1 = i; n1++; end
      if (req_ack[3] === 1'b1) begin a3 = i; n3++; end
    end
    check({n1[3:0], n3[3:0]}, 8'h11);
    check((a1 - a3 >= 2 && a1 - a3 <= 4) || (a3 - a1 >= 2 && a3 - a1 <= 4), 1);
    drain();
    check(seq.size(), 2);
  endtask
  task automatic t_stall();
    int c, n;
    tra_xfer_req_packet_t p;
    p.lvl = 2'h2; p.words = 8'h20; n = 0; seq.delete();
    @(posedge mclk) hold <= 1'b1;
    for (int i = 0; i < 4; i++) begin submit(1, 2'h2, 8'h20, 8, c); check(c <= 4, 1); end
    @(posedge mclk) drive(1, 1'b1, p);
    repeat (20) begin @(posedge mclk); #1; if (req_ack[1] === 1'b1) n++; end
    check(n, 0);
    check(req_stall[1], 1'b1);
    submit(3, 2'h1, 8'h02, 8, c);
    check(c <= 8, 1);
    @(posedge mclk) hold <= 1'b0;
    while (n < 400 && req_ack[1] !== 1'b1) begin @(posedge mclk); #1; n++; end
    check(req_ack[1], 1'b1);
    @(posedge mclk) drive(1, 1'b0, p);
    drain();
    check(seq.size(), 81);
  endtask
  task automatic t_prio();
    int c;
    logic [1:0] exp[$];
    @(posedge mclk) hold <= 1'b1;
    submit(1, 2'h2, 8'h20, 8, c);
    repeat (20) @(posedge mclk);
    submit(0, 2'h0, 8'h10, 8, c);
    submit(3, 2'h1, 8'h02, 8, c);
    repeat (4) @(posedge mclk);
    #1 check(xfer_active, 3'h7);
    seq.delete();
    // buffered low reads flush first, then urgent, high, rest of low
    for (int i = 0; i < 25; i++) exp.push_back(i < 8 ? 2'h2 : i < 16 ? 2'h0 : i < 17 ? 2'h1 : 2'h2);
    @(posedge mclk) hold <= 1'b0;
    drain();
    check(seq.size(), 25);
    for (int i = 0; i < 25 && i < seq.size(); i++) check(seq[i], exp[i]);
  endtask
  task automatic t_chan();
    int n;
    n = 0;
    @(posedge mclk) begin chan_words <= 8'h02; chan_evt_lvl <= 8'h09; chan_evt <= 4'h3; end
    @(posedge mclk) chan_evt <= 4'h0;
    repeat (30) begin @(posedge mclk); #1; if (req_ack[2] === 1'b1) n++; end
    check(n, 2);
    drain();
  endtask
  // ----------------------------------------
  // sequence and verdict
  // ----------------------------------------
  task automatic summarize();
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {rst_b, hold, cache_req_vld, quick_req_vld, host_req_vld, chan_evt, chan_evt_lvl, chan_words} = '0;
    cache_req = '0; quick_req = '0; host_req = '0;
    mismatches = 0; check_count = 0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_single();
    t_pair();
    t_stall();
    t_prio();
    t_chan();
    summarize();
  end
  // whole run is a few hundred cycles; this is ample headroom
  initial begin
    #500000;
    mismatches++;
    summarize();
  end
endmodule
